// ==== hdl/rst_cfg_pkg.sv ====
// Purpose: shared constants for reset and start-up sequencing
// Assumes: 20 MHz pclk, 32-bit APB register words
// Notes: config word is 14 bits, blank value all ones
package rst_cfg_pkg;
  localparam int CLK_MHZ = 20;
  // power-up timer, nominal 64 ms
  localparam int POWERUP_TIMER_TIME_US = 64000;
  localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_TIME_US * CLK_MHZ;
  localparam int POWERUP_TIMER_CNT_W = 21;
  // brown-out noise filter, least time
  localparam int BOR_FILTER_NS = 1000;
  localparam int BOR_FILTER_CYCLES = (BOR_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int BOR_CNT_W = 8;
  localparam int STACK_LEVELS = 16;
  localparam int STACK_W = 5;

  // register byte offsets
  localparam logic [7:0] CFG_WORD_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] CAUSE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;

  // configuration word fields
  localparam int CFG_W = 14;
  localparam logic [13:0] CFG_BLANK = 14'h3fff;
  localparam logic [13:0] CFG_UNIMPL_MASK = 14'h3104;
  localparam int CFG_CLKOUT_N = 11;
  localparam int CFG_BOR_LSB = 9;
  localparam int CFG_CP_N = 7;
  localparam int CFG_PIN_FN = 6;
  localparam int CFG_POWERUP_TIMER_N = 5;
  localparam int CFG_WDT_LSB = 3;
  localparam int CFG_OSC_LSB = 0;

  // control register fields and reset value
  localparam int CTRL_W = 5;
  localparam int CTRL_SBOR = 0;
  localparam int CTRL_SWDT = 1;
  localparam int CTRL_STKRST = 2;
  localparam int CTRL_BORLVL = 3;
  localparam int CTRL_LVP = 4;
  localparam logic [4:0] CTRL_RESET = 5'h14;

  // reset cause flags
  localparam int CAUSE_W = 5;
  localparam int CAUSE_OVF = 0;
  localparam int CAUSE_UNF = 1;
  localparam int CAUSE_POR = 2;
  localparam int CAUSE_BOR = 3;
  localparam int CAUSE_EXT = 4;
  localparam logic [4:0] CAUSE_RESET = 5'h04;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_AWAKE = 2'b10,
    MODE_ON = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    INTERNAL_OSCILLATOR = 2'b00,
    EXT_CLOCK_LOW_POWER = 2'b01,
    EXT_CLOCK_MEDIUM_POWER = 2'b10,
    EXT_CLOCK_HIGH_POWER = 2'b11
  } osc_t;
endpackage

// ==== hdl/stack_monitor.sv ====
// Purpose: tracks return stack depth and flags overflow or underflow
// Assumes: push and pop are one-cycle pulses, never both at once
// Notes: depth clears while the core is held in reset
`timescale 1ns/10ps
module stack_monitor
  import rst_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  output logic overflow,
  output logic underflow
);
  import rst_cfg_pkg::*;
  logic [STACK_W-1:0] depth_q;
  logic [STACK_W-1:0] depth_d;
  localparam logic [STACK_W-1:0] TOP = STACK_W'(STACK_LEVELS);

  assign overflow = push && (depth_q == TOP);
  assign underflow = pop && (depth_q == '0);
  assign depth_d = clear ? '0 :
                   (push && !overflow) ? depth_q + 1'b1 :
                   (pop && !underflow) ? depth_q - 1'b1 : depth_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= '0;
    end else begin
      depth_q <= depth_d;
    end
  end
endmodule

// ==== hdl/bor_filter.sv ====
// Purpose: rejects short supply dips before a brown-out trips
// Assumes: low input is synchronous to pclk
// Notes: trip holds for as long as the low level persists
`timescale 1ns/10ps
module bor_filter
  import rst_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic low,
  output logic trip
);
  import rst_cfg_pkg::*;
  localparam logic [BOR_CNT_W-1:0] LIMIT = BOR_CNT_W'(BOR_FILTER_CYCLES);
  logic [BOR_CNT_W-1:0] cnt_q;
  logic trip_q;

  assign trip = trip_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      trip_q <= 1'b0;
    end else if (!low) begin
      cnt_q <= '0;
      trip_q <= 1'b0;
    end else if (cnt_q < LIMIT) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      // dip has lasted longer than the filter time
      trip_q <= 1'b1;
    end
  end
endmodule

// ==== hdl/reset_startup_config.sv ====
// Purpose: reset sources, power-up timer and start-up gating with config decode
// Assumes: analog monitor levels and pins are synchronous to pclk
// Notes: APB slave, zero wait states, registers are 32-bit aligned words
//
// Behaviour
// R01 - stack fault reset enabled: reset on overflow or underflow, set matching flag
// R02 - brown-out mode 11 on, 10 awake only, 01 software bit, 00 off
// R03 - watchdog mode 11 on, 10 awake only, 01 software bit, 00 off
// R04 - power-up timer enabled when its config bit is 0
// R05 - power-up timer gives 64 ms after power-on or brown-out, holding reset
// R06 - power-up timer starts only after power-on and brown-out both release
// R07 - brown-out enable and power-up timer enable decode independently
// R08 - reset pin is external reset unless low-voltage programming off and bit 0
// R09 - held in reset while supply is below the power-on level
// R10 - held in reset while brown-out active and supply below trip level
// R11 - brown-out resets only when the low supply outlasts the filter time
// R12 - one configuration bit selects the brown-out trip level; the code takes it from control register bit BORLVL instead
// R13 - modes 11 and 10 awake wait for brown-out ready before executing
// R14 - code protect 0 blocks external access; only bulk erase clears it; the code also clears the latch on presetn
// R15 - oscillator field picks external clock power or internal oscillator
// R16 - clock output bit 0 drives clock out; 1 leaves the pin for I/O
// R17 - unimplemented configuration word bits read back as 1
// R18 - mode 10 wake from sleep waits for brown-out ready
// R19 - mode 01 start-up never waits; protection starts once circuit ready
// R20 - mode 11 keeps protection in sleep and never delays wake
// R21 - core reset ORs all sources and releases on the clock
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
module reset_startup_config
  import rst_cfg_pkg::*;
#(
  parameter int POWERUP_TIMER_LEN = rst_cfg_pkg::POWERUP_TIMER_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [rst_cfg_pkg::CFG_W-1:0] cfg_word_in,
  input wire logic bulk_erase,
  input wire logic por_low,
  input wire logic bor_low,
  input wire logic bor_ready,
  input wire logic external_reset_pin_n,
  input wire logic weak_pullup_ctrl,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic sleep_req,
  input wire logic wake_evt,
  output logic core_reset,
  output logic exec_enable,
  output logic sleeping,
  output logic bor_analog_en,
  output logic brownout_level_sel,
  output logic watchdog_en,
  output logic reset_pin_pullup_en,
  output logic reset_pin_digital_in,
  output logic ext_prog_access_block,
  output rst_cfg_pkg::osc_t oscillator_sel,
  output logic clock_input_pin_io,
  output logic clock_output_drive
);
  import rst_cfg_pkg::*;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_POWERUP_TIMER,
    ST_START,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } state_t;

  localparam logic [POWERUP_TIMER_CNT_W-1:0] POWERUP_TIMER_LAST = POWERUP_TIMER_CNT_W'(POWERUP_TIMER_LEN - 1);

  logic [CFG_W-1:0] cfg_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic [CAUSE_W-1:0] cause_q;
  logic [CAUSE_W-1:0] cause_d;
  logic [CAUSE_W-1:0] cause_set;
  logic [CAUSE_W-1:0] cause_clr;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic protect_q;
  logic core_reset_q;
  logic exec_q;
  logic powerup_timer_pending_q;
  logic [POWERUP_TIMER_CNT_W-1:0] powerup_timer_cnt_q;
  state_t state_q;
  state_t state_d;

  // bus decode
  wire setup_phase = psel && !penable;
  wire access_wr = psel && penable && pwrite;
  wire [7:0] ofs = paddr[7:0];
  wire hit_cfg = (ofs == CFG_WORD_OFS);
  wire hit_ctrl = (ofs == CTRL_OFS);
  wire hit_cause = (ofs == CAUSE_OFS);
  wire hit_status = (ofs == STATUS_OFS);
  // upper address bits must be zero for reads and error-free access; ctrl and cause writes decode only the low byte
  wire mapped = (paddr[31:8] == '0) && (hit_cfg || hit_ctrl || hit_cause || hit_status);

  // R17 unimplemented read as one
  wire [CFG_W-1:0] cfg_view = cfg_q | CFG_UNIMPL_MASK;

  // configuration field decode
  wire [1:0] bor_mode = cfg_q[CFG_BOR_LSB +: 2];
  wire [1:0] wdt_mode = cfg_q[CFG_WDT_LSB +: 2];
  // R04 power-up timer active low
  wire powerup_timer_en = !cfg_q[CFG_POWERUP_TIMER_N];
  wire lvp_en = ctrl_q[CTRL_LVP];
  wire stack_rst_en = ctrl_q[CTRL_STKRST];
  wire in_sleep = (state_q == ST_SLEEP);

  // R02 brown-out mode select
  wire bor_active = (bor_mode == MODE_ON) ||
                    ((bor_mode == MODE_AWAKE) && !in_sleep) ||
                    ((bor_mode == MODE_SOFT) && ctrl_q[CTRL_SBOR]);
  // R19 software mode guards only once the circuit is ready
  wire bor_protect = bor_active && ((bor_mode != MODE_SOFT) || bor_ready);
  // R13 start waits for ready in hardware modes
  wire start_needs_ready = (bor_mode == MODE_ON) || (bor_mode == MODE_AWAKE);

  // R03 watchdog mode select
  // same four-way table as brown-out, sleep read from the state register
  wire wdt_active = (wdt_mode == MODE_ON) ||
                    ((wdt_mode == MODE_AWAKE) && !in_sleep) ||
                    ((wdt_mode == MODE_SOFT) && ctrl_q[CTRL_SWDT]);

  // R08 reset pin function
  wire pin_is_reset = lvp_en || cfg_q[CFG_PIN_FN];
  wire ext_reset = pin_is_reset && !external_reset_pin_n;

  wire bor_trip;
  wire stack_ovf;
  wire stack_unf;

  // R11 dip filter
  // dips count only while protection is on, so sleep dips are ignored in awake-only mode
  bor_filter u_bor_filter (
    .pclk(pclk),
    .presetn(presetn),
    .low(bor_low && bor_protect),
    .trip(bor_trip)
  );

  // moves count only while executing; depth clears with core reset
  stack_monitor u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .clear(core_reset_q),
    .push(stack_push && exec_q),
    .pop(stack_pop && exec_q),
    .overflow(stack_ovf),
    .underflow(stack_unf)
  );

  // R01 stack fault reset when enabled
  wire stack_fault = stack_rst_en && (stack_ovf || stack_unf);
  // R09 R10 supply holds
  wire supply_hold = por_low || bor_trip;
  wire any_reset = supply_hold || ext_reset || stack_fault;
  wire powerup_timer_done = (powerup_timer_cnt_q == POWERUP_TIMER_LAST);
  // R06 R07 timer only after a supply reset, own enable bit only
  wire hold_to_powerup_timer = powerup_timer_pending_q && powerup_timer_en;
  // R13 R19 soft mode must not stall start on a circuit still settling
  wire start_go = !start_needs_ready || bor_ready;
  // R18 R20 only awake-only mode turned protection off on entering sleep
  wire wake_needs_ready = (bor_mode == MODE_AWAKE);

  // start-up sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        // R06 R07 timer starts after both releases, own enable only
        if (!any_reset) begin
          state_d = hold_to_powerup_timer ? ST_POWERUP_TIMER : ST_START;
        end
      end
      ST_POWERUP_TIMER: begin
        // R05 held for the full timeout
        if (powerup_timer_done) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        // R13 R19 ready gate on start
        // core reset is already released here; only execution waits
        if (start_go) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // R18 R20 awake-only mode re-checks ready, always-on does not
        if (wake_evt) begin
          state_d = wake_needs_ready ? ST_WAKE : ST_RUN;
        end
      end
      ST_WAKE: begin
        if (bor_ready) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
    // R21 any source overrides the sequence
    if (any_reset) begin
      state_d = ST_HOLD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_HOLD;
      core_reset_q <= 1'b1;
      exec_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // R21 registered core reset release
      core_reset_q <= (state_d == ST_HOLD) || (state_d == ST_POWERUP_TIMER);
      exec_q <= (state_d == ST_RUN);
    end
  end

  // R05 R06 timer counts only while supply resets are released
  // pending marks a supply reset; pin and stack resets skip the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerup_timer_pending_q <= 1'b1;
      powerup_timer_cnt_q <= '0;
    end else begin
      // a dip inside the timeout goes back to hold and restarts it
      if (supply_hold) begin
        powerup_timer_pending_q <= 1'b1;
      end else if (state_q == ST_START) begin
        powerup_timer_pending_q <= 1'b0;
      end
      if (state_q == ST_POWERUP_TIMER && !powerup_timer_done) begin
        powerup_timer_cnt_q <= powerup_timer_cnt_q + 1'b1;
      end else if (state_q != ST_POWERUP_TIMER) begin
        powerup_timer_cnt_q <= '0;
      end
    end
  end

  // nonvolatile word is sampled, blank until first edge
  // blank keeps every active-low enable off until the word arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_BLANK;
    end else begin
      cfg_q <= cfg_word_in;
    end
  end

  // R14 protection latch, set wins over erase
  // limitation: presetn clears the latch until the word is sampled again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_q <= 1'b0;
    end else if (!cfg_q[CFG_CP_N]) begin
      protect_q <= 1'b1;
    end else if (bulk_erase) begin
      protect_q <= 1'b0;
    end
  end

  // control register writes
  assign ctrl_d = (access_wr && hit_ctrl) ? pwdata[CTRL_W-1:0] : ctrl_q;

  // reset cause flags: write one to clear, a new event wins
  // R01 overflow and underflow flags
  assign cause_set[CAUSE_OVF] = stack_ovf;
  assign cause_set[CAUSE_UNF] = stack_unf;
  assign cause_set[CAUSE_POR] = por_low;
  assign cause_set[CAUSE_BOR] = bor_trip;
  assign cause_set[CAUSE_EXT] = ext_reset;
  assign cause_clr = (access_wr && hit_cause) ? pwdata[CAUSE_W-1:0] : '0;
  assign cause_d = cause_set | (cause_q & ~cause_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      cause_q <= CAUSE_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      cause_q <= cause_d;
    end
  end

  // read data mux
  // status is a live view with no storage of its own
  wire [31:0] status_word = {24'h000000, state_q != ST_RUN, protect_q, state_q == ST_POWERUP_TIMER,
                             wdt_active, bor_protect, bor_active, core_reset_q, bor_ready};
  assign rd_mux = hit_cfg ? {18'h00000, cfg_view} :
                  hit_ctrl ? {27'h0000000, ctrl_q} :
                  hit_cause ? {27'h0000000, cause_q} :
                  hit_status ? status_word : 32'h00000000;

  // read data settles in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_phase) begin
      prdata_q <= (mapped && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  // unmapped offsets and writes to read-only words are errored
  assign pslverr = psel && penable && (!mapped || (pwrite && (hit_cfg || hit_status)));

  // core control outputs
  assign core_reset = core_reset_q;
  assign exec_enable = exec_q;
  assign sleeping = in_sleep;
  assign bor_analog_en = bor_active;
  // R12 trip level select
  assign brownout_level_sel = ctrl_q[CTRL_BORLVL];
  assign watchdog_en = wdt_active;
  // R08 pull-up forced on while the pin is a reset input
  assign reset_pin_pullup_en = pin_is_reset || weak_pullup_ctrl;
  assign reset_pin_digital_in = !pin_is_reset;
  assign ext_prog_access_block = protect_q;
  // R15 oscillator source
  assign oscillator_sel = osc_t'(cfg_q[CFG_OSC_LSB +: 2]);
  assign clock_input_pin_io = (cfg_q[CFG_OSC_LSB +: 2] == INTERNAL_OSCILLATOR);
  // R16 clock output active low enable
  assign clock_output_drive = !cfg_q[CFG_CLKOUT_N];
endmodule

// ==== test/supply_model.sv ====
// Purpose: analog supply monitors and reset pin beside the block
// Assumes: levels change just after a pclk edge
// Notes: ready can lag the supply, so slow circuits can be shown
`timescale 1ns/10ps
module supply_model (
  input wire logic pclk,
  output logic por_low,
  output logic bor_low,
  output logic bor_ready,
  output logic external_reset_pin_n
);
  initial begin
    por_low = 1'b1;
    bor_low = 1'b1;
    bor_ready = 1'b0;
    external_reset_pin_n = 1'b1;
  end
  task automatic power_down();
    por_low <= 1'b1;
    bor_low <= 1'b1;
    bor_ready <= 1'b0;
  endtask
  task automatic power_up(input int dly);
    por_low <= 1'b0;
    bor_low <= 1'b0;
    repeat (dly) @(posedge pclk);
    bor_ready <= 1'b1;
  endtask
  task automatic dip(input int n);
    bor_low <= 1'b1;
    repeat (n) @(posedge pclk);
    bor_low <= 1'b0;
  endtask
  task automatic pin_low(input int n);
    external_reset_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    external_reset_pin_n <= 1'b1;
  endtask
  task automatic ready_gap(input int n);
    bor_ready <= 1'b0;
    repeat (n) @(posedge pclk);
    bor_ready <= 1'b1;
  endtask
endmodule

// ==== test/rst_cfg_monitor.sv ====
// Purpose: port checks for reset sequencing and config decode
// Assumes: single pclk domain, presetn asynchronous active low
// Notes: counters saturate so a long run never looks like a fresh start
`timescale 1ns/10ps
module rst_cfg_monitor
  import rst_cfg_pkg::*;
#(
  parameter int POWERUP_TIMER_LEN = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [rst_cfg_pkg::CFG_W-1:0] cfg_word_in,
  input wire logic por_low,
  input wire logic bor_low,
  input wire logic external_reset_pin_n,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic sleep_req,
  input wire logic core_reset,
  input wire logic exec_enable,
  input wire logic watchdog_en,
  input wire logic reset_pin_digital_in,
  input wire logic clock_input_pin_io
);
  import rst_cfg_pkg::*;
  logic [7:0] low_q;
  logic [7:0] low_d;
  logic [23:0] up_q;
  logic [23:0] up_d;
  assign low_d = bor_low ? low_q + {7'h0, low_q != 8'hff} : 8'h00;
  assign up_d = por_low ? 24'h0 : up_q + {23'h0, up_q != 24'hffffff};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 8'h00;
      up_q <= 24'h0;
    end else begin
      low_q <= low_d;
      up_q <= up_d;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_por_holds: assert property (por_low |=> core_reset && !exec_enable)
    else $error("run while supply below power-on level");
  a_pin_resets: assert property (!external_reset_pin_n && !reset_pin_digital_in |=> core_reset)
    else $error("reset pin low without core reset");
  a_timer_length: assert property ($fell(core_reset) && !cfg_word_in[CFG_POWERUP_TIMER_N] |-> up_q > POWERUP_TIMER_LEN)
    else $error("core reset released before power-up time");
  a_dip_rejected: assert property (exec_enable && bor_low && low_q < BOR_FILTER_CYCLES && !por_low
      && external_reset_pin_n && !sleep_req && !stack_push && !stack_pop |=> exec_enable)
    else $error("short dip caused a reset");
  a_bor_trips: assert property (bor_low && low_q == BOR_FILTER_CYCLES + 3
      && cfg_word_in[10:9] == MODE_ON |-> core_reset)
    else $error("long dip did not reset");
  a_cfg_ones: assert property (psel && penable && !pwrite && paddr == 32'h0
      |-> prdata[13:12] == 2'b11 && prdata[8] && prdata[2])
    else $error("unimplemented config bit read as zero");
  a_wdt_off: assert property ((cfg_word_in[4:3] == MODE_OFF) [*2] |-> !watchdog_en)
    else $error("watchdog on in off mode");
  a_clkin_free: assert property ((cfg_word_in[1:0] == 2'b00) [*2] |-> clock_input_pin_io)
    else $error("clock input pin not freed for internal oscillator");
endmodule
bind reset_startup_config rst_cfg_monitor #(.POWERUP_TIMER_LEN(POWERUP_TIMER_LEN)) rst_cfg_monitor_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .cfg_word_in, .por_low,
  .bor_low, .external_reset_pin_n, .stack_push, .stack_pop, .sleep_req, .core_reset,
  .exec_enable, .watchdog_en, .reset_pin_digital_in, .clock_input_pin_io
);

// ==== test/test_reset_startup_config.sv ====
// Purpose: self-checking bench for reset sequencing and config decode
// Assumes: short power-up timer, supply model on the analog side
// Notes: apb results are compared by a watcher against queued notes
`timescale 1ns/10ps
module test_reset_startup_config;
  import rst_cfg_pkg::*;
  localparam int PL = 50;
  localparam int FILT = BOR_FILTER_CYCLES;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [13:0] cfg_word_in = 14'h3fdf;
  logic bulk_erase = 1'b0;
  logic weak_pullup_ctrl = 1'b0;
  logic stack_push = 1'b0;
  logic stack_pop = 1'b0;
  logic sleep_req = 1'b0;
  logic wake_evt = 1'b0;
  logic seen_rst = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, por_low, bor_low, bor_ready, external_reset_pin_n, core_reset;
  logic exec_enable, sleeping, bor_analog_en, brownout_level_sel, watchdog_en;
  logic reset_pin_pullup_en, reset_pin_digital_in, ext_prog_access_block;
  logic clock_input_pin_io, clock_output_drive;
  osc_t oscillator_sel;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] m;
  logic [13:0] c;
  logic [4:0] r;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  always #25 pclk = ~pclk;
  supply_model supply_model_i (.pclk, .por_low, .bor_low, .bor_ready, .external_reset_pin_n);
  reset_startup_config #(.POWERUP_TIMER_LEN(PL)) reset_startup_config_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cfg_word_in, .bulk_erase, .por_low, .bor_low, .bor_ready, .external_reset_pin_n,
    .weak_pullup_ctrl, .stack_push, .stack_pop, .sleep_req, .wake_evt, .core_reset,
    .exec_enable, .sleeping, .bor_analog_en, .brownout_level_sel, .watchdog_en,
    .reset_pin_pullup_en, .reset_pin_digital_in, .ext_prog_access_block, .oscillator_sel,
    .clock_input_pin_io, .clock_output_drive
  );
  task automatic chk(input string s, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    end_of_test();
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e, input logic [31:0] mk);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    exp_q.push_back(e);
    msk_q.push_back(mk);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      k++;
      if (k > 20) give_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // sampled on the falling edge, clear of the rising-edge updates
  task automatic wait_ex(input logic v, output int cnt);
    cnt = 0;
    @(negedge pclk);
    while (exec_enable !== v) begin
      @(negedge pclk);
      cnt++;
      if (cnt > 400) give_up();
    end
    @(posedge pclk);
  endtask
  task automatic power_on(input logic [13:0] cw, input int dly, input int lo, input int hi);
    presetn <= 1'b0;
    cfg_word_in <= cw;
    supply_model_i.power_down();
    tick(5);
    presetn <= 1'b1;
    tick(2);
    fork
      supply_model_i.power_up(dly);
      wait_ex(1'b1, n);
    join
    chk("startup", n >= lo && n <= hi, 1'b1);
  endtask
  always @(posedge pclk) begin
    if (core_reset === 1'b1) seen_rst <= 1'b1;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      m = msk_q.pop_front();
      chk("apb", {pslverr, prdata & m}, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(5));
    @(posedge pclk);
    power_on(14'h3fff, 3, 0, 6);
    power_on(14'h3fdf, 3, PL, PL + 5);
    power_on(14'h3fdf, PL + 30, PL + 30, PL + 36);
    power_on(14'h3bdf, PL + 30, PL, PL + 5);
    for (int i = 0; i < 4; i++) begin
      c = 14'($urandom()) | 14'h0080;
      c[1:0] = i[1:0];
      r = 5'($urandom()) | 5'h04;
      cfg_word_in <= c;
      weak_pullup_ctrl <= 1'($urandom());
      apb(1'b1, CTRL_OFS, {27'h0, r}, 33'h0, 32'h0);
      apb(1'b0, CTRL_OFS, 32'h0, {28'h0, r}, 32'hffffffff);
      apb(1'b0, CFG_WORD_OFS, 32'h0, {19'h0, c | CFG_UNIMPL_MASK}, 32'hffffffff);
      @(negedge pclk);
      chk("osc", oscillator_sel, c[1:0]);
      chk("clkin", clock_input_pin_io, c[1:0] == 2'b00);
      chk("clkout", clock_output_drive, !c[11]);
      chk("level", brownout_level_sel, r[3]);
      chk("wdt", watchdog_en, c[4] | (c[3] & r[1]));
      chk("pin", reset_pin_digital_in, !r[4] & !c[6]);
      chk("pull", reset_pin_pullup_en, (!r[4] & !c[6]) ? weak_pullup_ctrl : 1'b1);
      tick(1);
    end
    apb(1'b0, 8'h10, 32'h0, 33'h100000000, 32'hffffffff);
    apb(1'b1, CFG_WORD_OFS, 32'h0, 33'h100000000, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h14, 33'h0, 32'h0);
    cfg_word_in <= 14'h3fdf;
    for (int j = 0; j < 3; j++) begin
      if (j == 2) supply_model_i.pin_low(3);
      else repeat (j ? 1 : STACK_LEVELS + 1) begin
        stack_push <= !j;
        stack_pop <= j[0];
        tick(1);
        stack_push <= 1'b0;
        stack_pop <= 1'b0;
        tick(1);
      end
      wait_ex(1'b0, n);
      wait_ex(1'b1, n);
      apb(1'b0, CAUSE_OFS, 32'h0, (j == 2) ? 33'h10 : 33'(j + 1), 32'h13);
      apb(1'b1, CAUSE_OFS, 32'h1f, 33'h0, 32'h0);
    end
    for (int j = 0; j < 3; j++) begin
      cfg_word_in <= (j == 2) ? 14'h39df : 14'h3fdf;
      tick(2);
      seen_rst <= 1'b0;
      supply_model_i.dip((j == 0) ? FILT - 4 : FILT + 10);
      tick(PL + 20);
      wait_ex(1'b1, n);
      chk("dip", seen_rst, j == 1);
    end
    apb(1'b0, CAUSE_OFS, 32'h0, 33'h08, 32'h08);
    for (int j = 0; j < 2; j++) begin
      cfg_word_in <= j ? 14'h3fdf : 14'h3dd7;
      tick(2);
      fork
        supply_model_i.ready_gap(30);
        begin
          sleep_req <= 1'b1;
          tick(1);
          sleep_req <= 1'b0;
          tick(3);
          @(negedge pclk);
          chk("asleep", sleeping, 1'b1);
          chk("bor_sleep", bor_analog_en, j[0]);
          chk("wdt_sleep", watchdog_en, j[0]);
          @(posedge pclk);
          wake_evt <= 1'b1;
          tick(1);
          wake_evt <= 1'b0;
          wait_ex(1'b1, n);
        end
      join
      chk("wake", n >= 20, j == 0);
    end
    cfg_word_in <= 14'h3f5f;
    tick(3);
    cfg_word_in <= 14'h3fdf;
    tick(3);
    @(negedge pclk);
    chk("protect", ext_prog_access_block, 1'b1);
    tick(1);
    apb(1'b0, STATUS_OFS, 32'h0, 33'h5d, 32'hffffffff);
    bulk_erase <= 1'b1;
    tick(1);
    bulk_erase <= 1'b0;
    tick(2);
    @(negedge pclk);
    chk("erase", ext_prog_access_block, 1'b0);
    end_of_test();
  end
endmodule
